// *** rtl/cpu_opcode_decode_and_timing.v ***
// Purpose: first-byte opcode decode and execution-state accounting
// Assumes: inputs synchronous to mclk_i; one instruction presented at a time
// Notes: result is registered one cycle after a valid strobe
`timescale 1ns/10ps
`default_nettype none
`include "opdec_map.vh"
module cpu_opcode_decode_and_timing (
    input wire mclk_i,
    input wire reset_n_i,
    input wire clk_en_i,
    input wire op_valid_i,
    input wire [15:0] op_word_i,
    input wire mem_operand_i,
    input wire bit_write_i,
    input wire [7:0] move_count_register_i,
    input wire data_to_peri_i,
    input wire peri_slow_i,
    output reg result_valid_o,
    output reg [4:0] op_class_o,
    output reg [3:0] cond_o,
    output reg [13:0] exec_states_o,
    output reg [3:0] byte_cost_o
);
    wire [4:0] cls;
    wire [3:0] cond;
    wire [3:0] c_fetch;
    wire [3:0] c_branch;
    wire [3:0] c_stack;
    wire [9:0] c_byte;
    wire [3:0] c_word;
    wire [4:0] c_int;
    reg [3:0] byte_cost;
    wire [13:0] w_fetch;
    wire [13:0] w_branch;
    wire [13:0] w_stack;
    wire [13:0] w_byte;
    wire [13:0] w_word;
    wire [13:0] w_int;
    wire [13:0] total;

    ////////////////////////////////////////////////////////////////////
    // Push and pop need no decode of their own: same codes as moves
    opcode_classifier u_class (
        .op_word_i(op_word_i),
        .mem_operand_i(mem_operand_i),
        .bit_write_i(bit_write_i),
        .move_count_register_i(move_count_register_i),
        .op_class_o(cls),
        .cond_o(cond),
        .cnt_fetch_o(c_fetch),
        .cnt_branch_o(c_branch),
        .cnt_stack_o(c_stack),
        .cnt_byte_o(c_byte),
        .cnt_word_o(c_word),
        .cnt_int_o(c_int)
    );

    ////////////////////////////////////////////////////////////////////
    // Slow modules stretch each byte cycle by one state
    always @* begin
        if (data_to_peri_i && peri_slow_i) begin
            byte_cost = `COST_PERI_SLOW;
        end else if (data_to_peri_i) begin
            byte_cost = `COST_PERI_FAST;
        end else begin
            byte_cost = `COST_MEM;
        end
    end

    state_weight u_w_fetch (
        .count_i({6'h00, c_fetch}),
        .cost_i(`COST_MEM),
        .weighted_o(w_fetch)
    );
    state_weight u_w_branch (
        .count_i({6'h00, c_branch}),
        .cost_i(`COST_MEM),
        .weighted_o(w_branch)
    );
    state_weight u_w_stack (
        .count_i({6'h00, c_stack}),
        .cost_i(`COST_MEM),
        .weighted_o(w_stack)
    );
    state_weight u_w_byte (
        .count_i(c_byte),
        .cost_i(byte_cost),
        .weighted_o(w_byte)
    );
    state_weight u_w_word (
        .count_i({6'h00, c_word}),
        .cost_i(`COST_MEM),
        .weighted_o(w_word)
    );
    state_weight u_w_int (
        .count_i({5'h00, c_int}),
        .cost_i(`COST_INT), // Independent of target
        .weighted_o(w_int)
    );

    // Max 2*256*3 plus small terms fits 14 bits
    assign total = w_fetch + w_branch + w_stack + w_byte + w_word + w_int;

    ////////////////////////////////////////////////////////////////////
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            result_valid_o <= 1'b0;
            op_class_o <= 5'h00;
            cond_o <= 4'h0;
            exec_states_o <= 14'h0000;
            byte_cost_o <= 4'h0;
        end else if (clk_en_i) begin
            result_valid_o <= op_valid_i;
            if (op_valid_i) begin
                op_class_o <= cls;
                cond_o <= cond;
                exec_states_o <= total;
                byte_cost_o <= byte_cost;
            end
        end
    end
endmodule // cpu_opcode_decode_and_timing
`default_nettype wire

// *** rtl/opcode_classifier.v ***
// Purpose: classify a first opcode byte and give per-type cycle counts
// Assumes: second-word hints come from the caller
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "opdec_map.vh"
module opcode_classifier (
    input wire [15:0] op_word_i,
    input wire mem_operand_i,
    input wire bit_write_i,
    input wire [7:0] move_count_register_i,
    output reg [4:0] op_class_o,
    output reg [3:0] cond_o,
    output reg [3:0] cnt_fetch_o,
    output reg [3:0] cnt_branch_o,
    output reg [3:0] cnt_stack_o,
    output reg [9:0] cnt_byte_o,
    output reg [3:0] cnt_word_o,
    output reg [4:0] cnt_int_o
);
    wire [7:0] first_byte;
    wire [3:0] row;
    wire [3:0] col;
    assign first_byte = op_word_i[`OP_HI_MSB:`OP_HI_LSB];
    assign row = first_byte[7:4];
    assign col = first_byte[3:0];

    always @* begin
        op_class_o = `CLS_OTHER;
        cond_o = 4'h0;
        cnt_fetch_o = 4'h1;
        cnt_branch_o = 4'h0;
        cnt_stack_o = 4'h0;
        cnt_byte_o = 10'h000;
        cnt_word_o = 4'h0;
        cnt_int_o = 5'h00;
        case (row)
            `ROW_SYS: begin
                case (col)
                    4'h0: op_class_o = `CLS_NOP;
                    4'h1: op_class_o = `CLS_SLEEP;
                    4'h2: op_class_o = `CLS_STFLAGS;
                    4'h3: op_class_o = `CLS_LDFLAGS;
                    4'h4: op_class_o = `CLS_ORFLAGS;
                    4'h5: op_class_o = `CLS_XORFLAGS;
                    4'h6: op_class_o = `CLS_ANDFLAGS;
                    4'h7: op_class_o = `CLS_LDFLAGS;
                    default: op_class_o = `CLS_OTHER;
                endcase
                // Single fetch, nothing else
            end
            `ROW_BRANCH: begin
                op_class_o = `CLS_BRANCH;
                cond_o = col;
                cnt_fetch_o = 4'h2; // Taken or not
            end
            `ROW_MISC: begin
                case (col)
                    `COL_MULU: begin
                        op_class_o = `CLS_MULU;
                        cnt_int_o = `MULDIV_INT_STATES;
                    end
                    `COL_DIVU: begin
                        op_class_o = `CLS_DIVU;
                        cnt_int_o = `MULDIV_INT_STATES;
                    end
                    `COL_RTS: begin
                        op_class_o = `CLS_RTS;
                        cnt_fetch_o = 4'h2;
                        cnt_stack_o = 4'h1;
                        cnt_int_o = 5'h02;
                    end
                    `COL_BSR: begin
                        op_class_o = `CLS_BSR;
                        cnt_fetch_o = 4'h2;
                        cnt_stack_o = 4'h1;
                    end
                    `COL_RTE: begin
                        op_class_o = `CLS_RTE;
                        cnt_fetch_o = 4'h2;
                        cnt_stack_o = 4'h2;
                        cnt_int_o = 5'h02;
                    end
                    `COL_JMP: begin
                        op_class_o = `CLS_JMP;
                        cnt_fetch_o = 4'h2;
                    end
                    `COL_JSR: begin
                        op_class_o = `CLS_JSR;
                        cnt_fetch_o = 4'h2;
                        cnt_stack_o = 4'h1;
                    end
                    default: op_class_o = `CLS_OTHER;
                endcase
            end
            `ROW_BITOP, `ROW_BITEXT: begin
                if (row == `ROW_BITEXT && col == `COL_BLKMOVE) begin
                    op_class_o = `CLS_BLKMOVE;
                    cnt_fetch_o = 4'h2;
                    cnt_int_o = 5'h01;
                    cnt_byte_o = {1'b0, move_count_register_i, 1'b0} + 10'h002;
                end else if (row == `ROW_BITEXT && col == `COL_MOVDISP) begin
                    op_class_o = op_word_i[7] ? `CLS_WSTDISP : `CLS_MOVE;
                    cnt_fetch_o = 4'h2;
                    cnt_word_o = 4'h1;
                end else if (mem_operand_i) begin
                    cnt_fetch_o = 4'h2;
                    if (bit_write_i) begin
                        op_class_o = `CLS_BITWR;
                        cnt_byte_o = 10'h002; // Read then write back
                    end else begin
                        op_class_o = `CLS_BITRD;
                        cnt_byte_o = 10'h001; // Read only
                    end
                end else begin
                    op_class_o = bit_write_i ? `CLS_BITWR : `CLS_BITRD;
                end
            end
            `ROW_MOVB_2, `ROW_MOVB_3: begin
                op_class_o = `CLS_MOVE;
                cnt_byte_o = 10'h001;
            end
            default: op_class_o = `CLS_OTHER;
        endcase
    end
endmodule // opcode_classifier
`default_nettype wire

// *** rtl/opdec_map.vh ***
// Purpose: constants for the opcode decode and state accounting block
// Assumes: first opcode byte is bits 15..8 of the first instruction word
// Notes: state costs per cycle type, opcode rows and columns
`ifndef OPDEC_MAP_VH
`define OPDEC_MAP_VH

`define COST_MEM 4'h2
`define COST_INT 4'h1
`define COST_PERI_FAST 4'h2
`define COST_PERI_SLOW 4'h3
`define MULDIV_INT_STATES 5'h0C
`define OP_HI_MSB 15
`define OP_HI_LSB 8
`define ROW_SYS 4'h0
`define ROW_ALU1 4'h1
`define ROW_BRANCH 4'h4
`define ROW_MISC 4'h5
`define ROW_BITOP 4'h6
`define ROW_BITEXT 4'h7
`define ROW_MOVB_2 4'h2
`define ROW_MOVB_3 4'h3
`define ROW_MOVW_F 4'hF
`define COL_MULU 4'h0
`define COL_DIVU 4'h1
`define COL_RTS 4'h4
`define COL_BSR 4'h5
`define COL_RTE 4'h6
`define COL_JMP 4'hA
`define COL_JSR 4'hE
`define COL_MOVDISP 4'h9
`define COL_BLKMOVE 4'hB
`define COL_MOVGEN 4'h8
`define COL_MOVIND 4'h9
`define COL_MOVINC 4'hD
`define COL_MOVABS 4'hA
`define COL_MOVABS16 4'hB

`define CLS_OTHER 5'h00
`define CLS_NOP 5'h01
`define CLS_SLEEP 5'h02
`define CLS_STFLAGS 5'h03
`define CLS_LDFLAGS 5'h04
`define CLS_ORFLAGS 5'h05
`define CLS_XORFLAGS 5'h06
`define CLS_ANDFLAGS 5'h07
`define CLS_BRANCH 5'h08
`define CLS_MULU 5'h09
`define CLS_DIVU 5'h0A
`define CLS_RTS 5'h0B
`define CLS_BSR 5'h0C
`define CLS_RTE 5'h0D
`define CLS_BITWR 5'h0E
`define CLS_BITRD 5'h0F
`define CLS_BLKMOVE 5'h10
`define CLS_WSTDISP 5'h11
`define CLS_MOVE 5'h12
`define CLS_JMP 5'h13
`define CLS_JSR 5'h14

`endif

// *** rtl/state_weight.v ***
// Purpose: multiply one cycle-type count by its state cost
// Assumes: count and cost are unsigned
// Notes: one instance per cycle type
`timescale 1ns/10ps
`default_nettype none
module state_weight (
    input wire [9:0] count_i,
    input wire [3:0] cost_i,
    output wire [13:0] weighted_o
);
    assign weighted_o = count_i * cost_i;
endmodule // state_weight
`default_nettype wire

// *** testbench/opdec_timing_monitor.sv ***
// Purpose: port-level timing checks for the opcode decode and state accounting block
// Assumes: one clock, asynchronous active-low reset
// Notes: byte cost taken as 3 only for a slow peripheral target
`timescale 1ns/10ps
`default_nettype none
module opdec_timing_monitor (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic op_valid_i,
    input wire logic [15:0] op_word_i,
    input wire logic mem_operand_i,
    input wire logic bit_write_i,
    input wire logic [7:0] move_count_register_i,
    input wire logic data_to_peri_i,
    input wire logic peri_slow_i,
    input wire logic result_valid_o,
    input wire logic [4:0] op_class_o,
    input wire logic [3:0] cond_o,
    input wire logic [13:0] exec_states_o,
    input wire logic [3:0] byte_cost_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    logic go;
    logic [3:0] c;
    assign go = clk_en_i && op_valid_i;
    assign c = (data_to_peri_i && peri_slow_i) ? 4'h3 : 4'h2;
    ////////////////////////////////////////////////////////////////////////
    valid_pulse_a: assert property (go |=> result_valid_o) else $error("no result");
    idle_quiet_a: assert property (clk_en_i && !op_valid_i |=> !result_valid_o)
        else $error("spurious result");
    // Enable low must freeze the pulse as well as the data
    freeze_hold_a: assert property (!clk_en_i |=> $stable(result_valid_o)
        && $stable(exec_states_o) && $stable(op_class_o)) else $error("not frozen");
    mul_states_a: assert property (go && op_word_i[15:8] == 8'h50 |=>
        op_class_o == 5'h09 && exec_states_o == 14'h000E) else $error("multiply wrong");
    div_states_a: assert property (go && op_word_i[15:8] == 8'h51 |=>
        op_class_o == 5'h0A && exec_states_o == 14'h000E) else $error("divide wrong");
    branch_dec_a: assert property (go && op_word_i[15:12] == 4'h4 |=>
        op_class_o == 5'h08 && cond_o == $past(op_word_i[11:8]) && exec_states_o == 14'h0004)
        else $error("branch wrong");
    flag_imm_a: assert property (go && op_word_i[15:8] inside {8'h04, 8'h05, 8'h06}
        |=> exec_states_o == 14'h0002) else $error("flag op states wrong");
    blk_move_a: assert property (go && op_word_i[15:8] == 8'h7B |=> exec_states_o ==
        14'h0005 + (14'h0002 * $past(move_count_register_i) + 14'h0002) * $past(c))
        else $error("block move states wrong");
    bit_write_a: assert property (go && op_word_i[15:12] == 4'h6 && mem_operand_i
        && bit_write_i |=> exec_states_o == 14'h0004 + 14'h0002 * $past(c))
        else $error("bit write states wrong");
    bit_read_a: assert property (go && op_word_i[15:12] == 4'h6 && mem_operand_i
        && !bit_write_i |=> exec_states_o == 14'h0004 + $past(c)) else $error("bit read wrong");
    byte_cost_a: assert property (go |=> byte_cost_o == $past(c))
        else $error("byte cost wrong");
    word_store_a: assert property (go && op_word_i[15:8] == 8'h79 && op_word_i[7]
        |=> op_class_o == 5'h11 && exec_states_o == 14'h0006) else $error("word store wrong");
endmodule // opdec_timing_monitor
bind cpu_opcode_decode_and_timing opdec_timing_monitor u_mon (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .op_valid_i(op_valid_i), .op_word_i(op_word_i),
    .mem_operand_i(mem_operand_i), .bit_write_i(bit_write_i), .data_to_peri_i(data_to_peri_i),
    .move_count_register_i(move_count_register_i), .peri_slow_i(peri_slow_i),
    .result_valid_o(result_valid_o), .op_class_o(op_class_o), .cond_o(cond_o),
    .exec_states_o(exec_states_o), .byte_cost_o(byte_cost_o));
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench for opcode decode and state accounting
// Assumes: inputs driven at the falling edge, results seen just after the rising edge
// Notes: a frozen edge brings no new result, so a held pulse is not matched again
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin n_fail++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic mclk_i = 0, reset_n_i = 0, clk_en_i = 0, op_valid_i = 0, mem_operand_i = 0;
    logic bit_write_i = 0, data_to_peri_i = 0, peri_slow_i = 0, result_valid_o;
    logic [15:0] op_word_i = 16'h0000;
    logic [7:0] move_count_register_i = 8'h00;
    logic [4:0] op_class_o;
    logic [3:0] cond_o, byte_cost_o, c;
    logic [13:0] exec_states_o;
    logic [22:0] e;
    logic [22:0] expq[$];
    logic [31:0] r, seed;
    logic en_seen;
    int n_fail = 0, compares = 0;
    logic [3:0] col5 [7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'hA, 4'hE};
    logic [4:0] cls5 [7] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h13, 5'h14};
    logic [13:0] st5 [7] = '{14'h000E, 14'h000E, 14'h0008, 14'h0006, 14'h000A,
        14'h0004, 14'h0006};
    always #4 mclk_i = ~mclk_i;
    cpu_opcode_decode_and_timing u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i), .op_valid_i(op_valid_i), .op_word_i(op_word_i),
        .mem_operand_i(mem_operand_i), .bit_write_i(bit_write_i),
        .move_count_register_i(move_count_register_i), .data_to_peri_i(data_to_peri_i),
        .peri_slow_i(peri_slow_i), .result_valid_o(result_valid_o), .op_class_o(op_class_o),
        .cond_o(cond_o), .exec_states_o(exec_states_o), .byte_cost_o(byte_cost_o));
    ////////////////////////////////////////////////////////////////////////
    task send(input logic [15:0] w, input logic m, input logic wr, input logic [7:0] n,
              input logic p, input logic s, input logic [4:0] cls, input logic [13:0] st);
        @(negedge mclk_i);
        {op_word_i, mem_operand_i, bit_write_i, move_count_register_i} = {w, m, wr, n};
        {data_to_peri_i, peri_slow_i, clk_en_i, op_valid_i} = {p, s, 2'b11};
        expq.push_back({cls, (w[15:12] == 4'h4) ? w[11:8] : 4'h0, st});
    endtask
    task drain(input string nm);
        @(negedge mclk_i);
        {clk_en_i, op_valid_i} = 2'b10;
        repeat (40) if (expq.size() != 0) @(negedge mclk_i);
        if (expq.size() != 0) begin
            n_fail++;
            $display("[FAIL] %s queue exp 0 got %0d", nm, expq.size());
            tally_and_finish();
        end else begin
            $display("test %s done", nm);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Only enabled edges bring a new result; an extra pulse finds an empty queue
    always @(posedge mclk_i) begin
        en_seen = clk_en_i;
        #1;
        if (en_seen && result_valid_o === 1'b1) begin
            if (expq.size() == 0) begin n_fail++; $display("[FAIL] pulse exp 0 got 1"); end
            else begin
                e = expq.pop_front();
                `CHK("class", e[22:18], op_class_o)
                `CHK("cond", e[17:14], cond_o)
                `CHK("states", e[13:0], exec_states_o)
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hA2069919;
        repeat (20) @(negedge mclk_i);
        `CHK("reset states", 14'h0000, exec_states_o)
        reset_n_i = 1;
        for (int i = 0; i < 8; i++) send({4'h0, i[3:0], 8'h00}, 0, 0, 0, 0, 0,
            (i == 7) ? 5'h04 : 5'(i + 1), 14'h0002);
        for (int i = 0; i < 16; i++) send({4'h4, i[3:0], 8'h5A}, 0, 0, 0, 0, 0, 5'h08, 14'h0004);
        for (int i = 0; i < 7; i++) send({4'h5, col5[i], 8'h10}, 0, 0, 0, 0, 0, cls5[i], st5[i]);
        drain("rows 0 4 5");
        repeat (24) begin
            r = $random(seed);
            c = (r[5] && r[6]) ? 4'h3 : 4'h2;
            send({5'h0C, r[2:0], r[15:8]}, 1, r[4], r[23:16], r[5], r[6], r[4] ? 5'h0E : 5'h0F,
                r[4] ? 14'h0004 + 14'h0002 * c : 14'h0004 + c);
            send({4'h2, r[19:8]}, 0, 0, 0, r[5], r[6], 5'h12, 14'h0002 + c);
            send({5'h0C, r[2:0], r[15:8]}, 0, r[4], 0, r[5], r[6], r[4] ? 5'h0E : 5'h0F,
                14'h0002);
        end
        drain("bit ops and moves");
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            c = (r[8] && r[9]) ? 4'h3 : 4'h2;
            r[7:0] = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : r[7:0];
            send(16'h7B5C, 0, 0, r[7:0], r[8], r[9], 5'h10,
                14'h0005 + (14'h0002 * r[7:0] + 14'h0002) * c);
        end
        send(16'h7980, 0, 0, 0, 0, 0, 5'h11, 14'h0006);
        send(16'h7900, 0, 0, 0, 0, 0, 5'h12, 14'h0006);
        send(16'h1400, 0, 0, 0, 0, 0, 5'h00, 14'h0002);
        drain("block move and word store");
        send(16'h5100, 0, 0, 0, 0, 0, 5'h0A, 14'h000E);
        @(negedge mclk_i);
        {clk_en_i, op_valid_i, op_word_i} = {2'b01, 16'h5400};
        repeat (4) @(negedge mclk_i);
        `CHK("frozen pulse", 1'b1, result_valid_o)
        `CHK("frozen class", 5'h0A, op_class_o)
        `CHK("frozen states", 14'h000E, exec_states_o)
        drain("clock enable freeze");
        reset_n_i = 0;
        repeat (2) @(negedge mclk_i);
        `CHK("mid reset class", 5'h00, op_class_o)
        reset_n_i = 1;
        send(16'h5000, 0, 0, 0, 1, 1, 5'h09, 14'h000E);
        drain("second reset");
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
